// [hdl/pbci_port.sv]
// Notes on behaviour
// - Eight bidirectional pins, each with direction bit and output latch bit.
// - Direction bit one makes the pin an input, driver off.
// - Direction bit zero drives the pin from its output latch.
// - Clearing option bit 7 turns on weak pull-ups of all pins.
// - Pull-up is forced off on any pin set as output.
// - Pull-ups are disabled after power-on reset.
// - Only upper four input pins take part in change detection.
// - Each such pin compares against value latched at last port read or write.
// - Mismatches ORed together set change flag at control bit 0.
// - Flag keeps being set while mismatch remains; clears do not stick.
// - Port read or write ends mismatch; software then clears the flag.
// - Port change event can wake the device from sleep.
// - Flags set regardless of individual or global enable bits.
// - Lowest pin is external interrupt; edge chosen by option bit 6.
//
// The address-and-strobe port and the register offsets were decided locally.
module pbci_port
    import pbci_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire logic [REG_AW-1:0] addr_i,
    input  wire logic [PORT_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [PORT_W-1:0]      rdata_o,
    input  wire logic [PORT_W-1:0] pin_i,
    output logic [PORT_W-1:0]      pin_o,
    output logic [PORT_W-1:0]      pin_oe_o,
    output logic [PORT_W-1:0]      pullup_en_o,
    output logic                   cpu_int_o,
    output logic                   wake_o,
    output logic                   irq_o
);

    logic [PORT_W-1:0] port_b_data_q;
    logic [PORT_W-1:0] port_b_direction_q;
    logic [PORT_W-1:0] option_control_q;
    logic [PORT_W-1:0] int_control_q;
    logic [PORT_W-1:0] int_control_d;
    logic [PORT_W-1:0] int_stat_q;
    logic [PORT_W-1:0] int_stat_d;
    logic [PORT_W-1:0] int_mask_q;
    logic [PORT_W-1:0] rdata_d;
    logic              ext_pin_q;
    pbci_pins_t        pins;

    // Address decode
    wire sel_data = (addr_i == ADDR_PORT_DATA);
    wire sel_dir  = (addr_i == ADDR_PORT_DIR);
    wire sel_opt  = (addr_i == ADDR_OPTION);
    wire sel_ictl = (addr_i == ADDR_INT_CTRL);
    wire sel_stat = (addr_i == ADDR_INT_STAT);
    wire sel_mask = (addr_i == ADDR_INT_MASK);

    wire port_touch = (rd_i | wr_i) & sel_data;

    // Pin drive and pull-ups
    assign pins.oe      = ~port_b_direction_q;
    assign pins.out     = port_b_data_q & pins.oe;
    assign pins.pull_en = {PORT_W{~option_control_q[OPT_PULLUP_N_BIT]}} & port_b_direction_q;
    assign pin_o        = pins.out;
    assign pin_oe_o     = pins.oe;
    assign pullup_en_o  = pins.pull_en;

    // Change detection on the upper four pins
    logic chg_mismatch;

    pbci_chg_det u_chg (
        .ref_clk_i  (ref_clk_i),
        .rstn_i     (rstn_i),
        .pin_i      (pin_i[CHG_LO +: CHG_W]),
        .is_input_i (port_b_direction_q[CHG_LO +: CHG_W]),
        .capture_i  (port_touch),
        .mismatch_o (chg_mismatch)
    );

    // External interrupt edge on the lowest pin
    wire        ext_now  = pin_i[EXT_PIN];
    pbci_edge_t edge_sel;
    assign edge_sel = pbci_edge_t'(option_control_q[OPT_EDGE_SEL_BIT]);
    wire ext_rise = ext_now & ~ext_pin_q;
    wire ext_fall = ~ext_now & ext_pin_q;
    wire ext_evt  = (edge_sel == PBCI_EDGE_RISE) ? ext_rise : ext_fall;

    // Control register: set wins over a software clear
    always_comb begin
        int_control_d = int_control_q;
        if (wr_i && sel_ictl) begin
            int_control_d = wdata_i;
        end
        if (chg_mismatch) begin
            int_control_d[ICTL_CHG_FLG_BIT] = 1'b1;
        end
        if (ext_evt) begin
            int_control_d[ICTL_EXT_FLG_BIT] = 1'b1;
        end
    end

    // Sticky status, write one to clear, set wins
    always_comb begin
        int_stat_d = int_stat_q;
        if (wr_i && sel_stat) begin
            int_stat_d = int_stat_q & ~wdata_i;
        end
        if (chg_mismatch) begin
            int_stat_d[STAT_CHG_BIT] = 1'b1;
        end
        if (ext_evt) begin
            int_stat_d[STAT_EXT_BIT] = 1'b1;
        end
    end

    // Read mux; port data reads pins on inputs, latch on outputs
    wire [PORT_W-1:0] port_view = (pin_i & port_b_direction_q) | (port_b_data_q & ~port_b_direction_q);
    assign rdata_d = !rd_i    ? ZERO_BYTE :
                     sel_data ? port_view :
                     sel_dir  ? port_b_direction_q :
                     sel_opt  ? option_control_q :
                     sel_ictl ? int_control_q :
                     sel_stat ? int_stat_q :
                     sel_mask ? int_mask_q : ZERO_BYTE;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            port_b_data_q      <= RST_LATCH;
            port_b_direction_q <= RST_DIR;
            option_control_q   <= RST_OPTION;
            int_control_q      <= RST_ICTL;
            int_stat_q         <= RST_STAT;
            int_mask_q         <= RST_MASK;
            ext_pin_q          <= 1'b0;
            rdata_o            <= ZERO_BYTE;
        end else begin
            if (wr_i && sel_data) port_b_data_q <= wdata_i;
            if (wr_i && sel_dir)  port_b_direction_q <= wdata_i;
            if (wr_i && sel_opt)  option_control_q <= wdata_i;
            if (wr_i && sel_mask) int_mask_q <= wdata_i;
            int_control_q <= int_control_d;
            int_stat_q    <= int_stat_d;
            ext_pin_q     <= ext_now;
            rdata_o       <= rdata_d;
        end
    end

    // Wake needs only the individual enable, not the global one
    wire chg_pend = int_control_q[ICTL_CHG_FLG_BIT] & int_control_q[ICTL_CHG_EN_BIT];
    wire ext_pend = int_control_q[ICTL_EXT_FLG_BIT] & int_control_q[ICTL_EXT_EN_BIT];
    assign wake_o    = chg_pend | ext_pend;
    assign cpu_int_o = wake_o & int_control_q[ICTL_GIE_BIT];
    assign irq_o     = |(int_stat_q & int_mask_q);

    flag_sets_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        chg_mismatch |=> int_control_q[ICTL_CHG_FLG_BIT]) else $error("Change flag missed");
    flag_holds_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (chg_mismatch && wr_i && sel_ictl && !wdata_i[ICTL_CHG_FLG_BIT]) |=> int_control_q[ICTL_CHG_FLG_BIT])
        else $error("Clear beat mismatch");
    flag_no_enable_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (ext_evt && !int_control_q[ICTL_GIE_BIT]) |=> int_control_q[ICTL_EXT_FLG_BIT])
        else $error("Ext flag gated");
    drive_dir_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        pin_oe_o == ~port_b_direction_q) else $error("Driver enable wrong");
    drive_data_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_i && sel_data && port_b_direction_q == ZERO_BYTE) |=> pin_o == $past(wdata_i))
        else $error("Pin not driven from latch");
    pull_out_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (pullup_en_o & ~port_b_direction_q) == ZERO_BYTE) else $error("Pull-up on output");
    pull_global_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        option_control_q[OPT_PULLUP_N_BIT] |-> pullup_en_o == ZERO_BYTE) else $error("Pull-up not off");
    pull_reset_a: assert property (@(posedge ref_clk_i)
        !rstn_i |=> pullup_en_o == ZERO_BYTE) else $error("Pull-up on after reset");
    ext_edge_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (option_control_q[OPT_EDGE_SEL_BIT] && $rose(pin_i[EXT_PIN])) |=> int_control_q[ICTL_EXT_FLG_BIT])
        else $error("Rising edge missed");
    touch_ends_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (rd_i && sel_data && port_b_direction_q[CHG_LO +: CHG_W] == 4'hf) ##1 $stable(pin_i) |-> !chg_mismatch)
        else $error("Read did not end mismatch");
    read_data_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (rd_i && sel_data && port_b_direction_q == RST_DIR) |=> rdata_o == $past(pin_i))
        else $error("Read wrong pins");
    wake_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (int_control_q[ICTL_CHG_FLG_BIT] && int_control_q[ICTL_CHG_EN_BIT]) |-> wake_o)
        else $error("No wake");
    wake_ext_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (int_control_q[ICTL_EXT_FLG_BIT] && int_control_q[ICTL_EXT_EN_BIT]) |-> wake_o)
        else $error("No wake on ext");
    wake_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (!int_control_q[ICTL_CHG_FLG_BIT] && !int_control_q[ICTL_EXT_FLG_BIT]) |-> !wake_o)
        else $error("Wake without flag");
    cpu_gie_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !int_control_q[ICTL_GIE_BIT] |-> !cpu_int_o)
        else $error("Interrupt without global enable");
    cpu_pass_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wake_o && int_control_q[ICTL_GIE_BIT]) |-> cpu_int_o)
        else $error("Interrupt lost");

    // Status and mask: status bits mirror the flags but are cleared separately
    stat_sets_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        chg_mismatch |=> int_stat_q[STAT_CHG_BIT])
        else $error("Change status missed");
    stat_ext_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ext_evt |=> int_stat_q[STAT_EXT_BIT])
        else $error("Ext status missed");
    ext_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ext_evt |=> int_control_q[ICTL_EXT_FLG_BIT])
        else $error("Ext flag missed");
    stat_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_i && sel_stat && wdata_i[STAT_CHG_BIT] && !chg_mismatch) |=> !int_stat_q[STAT_CHG_BIT])
        else $error("Change status not cleared");
    stat_ext_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_i && sel_stat && wdata_i[STAT_EXT_BIT] && !ext_evt) |=> !int_stat_q[STAT_EXT_BIT])
        else $error("Ext status not cleared");
    stat_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_i && sel_stat && !wdata_i[STAT_CHG_BIT] && int_stat_q[STAT_CHG_BIT]) |=> int_stat_q[STAT_CHG_BIT])
        else $error("Status lost on zero write");
    irq_on_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (int_stat_q[STAT_CHG_BIT] && int_mask_q[STAT_CHG_BIT]) |-> irq_o)
        else $error("Irq missing");
    irq_off_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ((int_stat_q & int_mask_q) == ZERO_BYTE) |-> !irq_o)
        else $error("Irq without cause");

    // Flags move only on an event or a control write
    ictl_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_i && sel_ictl && !wdata_i[ICTL_CHG_FLG_BIT] && !chg_mismatch) |=> !int_control_q[ICTL_CHG_FLG_BIT])
        else $error("Change flag not cleared");
    chg_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (!chg_mismatch && !(wr_i && sel_ictl)) |=> $stable(int_control_q[ICTL_CHG_FLG_BIT]))
        else $error("Change flag moved");
    ext_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (!ext_evt && !(wr_i && sel_ictl)) |=> $stable(int_control_q[ICTL_EXT_FLG_BIT]))
        else $error("Ext flag moved");
    ext_fall_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (!option_control_q[OPT_EDGE_SEL_BIT] && $fell(pin_i[EXT_PIN])) |=> int_control_q[ICTL_EXT_FLG_BIT])
        else $error("Falling edge missed");
    ictl_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_i && sel_ictl) |=> int_control_q[ICTL_GIE_BIT] == $past(wdata_i[ICTL_GIE_BIT]))
        else $error("Global enable not written");

    // Change detection scope
    chg_outputs_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (~|port_b_direction_q[CHG_LO +: CHG_W]) |-> !chg_mismatch)
        else $error("Output pin compared");
    touch_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_i && sel_data && port_b_direction_q[CHG_LO +: CHG_W] == 4'hf) ##1 $stable(pin_i) |-> !chg_mismatch)
        else $error("Write did not end mismatch");

    // Values forced by reset
    oe_reset_a: assert property (@(posedge ref_clk_i)
        !rstn_i |=> pin_oe_o == ZERO_BYTE) else $error("Driver on after reset");
    out_reset_a: assert property (@(posedge ref_clk_i)
        !rstn_i |=> pin_o == ZERO_BYTE) else $error("Pin out after reset");
    ictl_reset_a: assert property (@(posedge ref_clk_i)
        !rstn_i |=> int_control_q == RST_ICTL) else $error("Control not reset");
    stat_reset_a: assert property (@(posedge ref_clk_i)
        !rstn_i |=> (int_stat_q == RST_STAT && int_mask_q == RST_MASK)) else $error("Status not reset");
    rdata_reset_a: assert property (@(posedge ref_clk_i)
        !rstn_i |=> rdata_o == ZERO_BYTE) else $error("Read data not reset");

    // Register port: read data stand one cycle only
    rdata_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !rd_i |=> rdata_o == ZERO_BYTE) else $error("Read data stuck");
    read_dir_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (rd_i && sel_dir) |=> rdata_o == $past(port_b_direction_q)) else $error("Direction read wrong");
    read_opt_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (rd_i && sel_opt) |=> rdata_o == $past(option_control_q)) else $error("Option read wrong");
    read_ictl_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (rd_i && sel_ictl) |=> rdata_o == $past(int_control_q)) else $error("Control read wrong");
    read_stat_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (rd_i && sel_stat) |=> rdata_o == $past(int_stat_q)) else $error("Status read wrong");
    read_mask_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (rd_i && sel_mask) |=> rdata_o == $past(int_mask_q)) else $error("Mask read wrong");
    read_unmapped_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (rd_i && addr_i > ADDR_INT_MASK) |=> rdata_o == ZERO_BYTE) else $error("Unmapped read not zero");
    read_latch_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (rd_i && sel_data) |=> (rdata_o & ~$past(port_b_direction_q)) == $past(port_b_data_q & ~port_b_direction_q))
        else $error("Output pins read wrong");

    // Register writes land and nothing else moves them
    write_latch_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_i && sel_data) |=> port_b_data_q == $past(wdata_i)) else $error("Latch not written");
    write_dir_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_i && sel_dir) |=> port_b_direction_q == $past(wdata_i)) else $error("Direction not written");
    write_opt_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_i && sel_opt) |=> option_control_q == $past(wdata_i)) else $error("Option not written");
    write_mask_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_i && sel_mask) |=> int_mask_q == $past(wdata_i)) else $error("Mask not written");
    dir_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !(wr_i && sel_dir) |=> $stable(port_b_direction_q)) else $error("Direction moved");
    opt_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !(wr_i && sel_opt) |=> $stable(option_control_q)) else $error("Option moved");
    latch_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !(wr_i && sel_data) |=> $stable(port_b_data_q)) else $error("Latch moved");

    // Pin side; a driven input pin would fight the keypad
    out_off_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (pin_o & port_b_direction_q) == ZERO_BYTE) else $error("Input pin driven");
    pull_input_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !option_control_q[OPT_PULLUP_N_BIT] |-> pullup_en_o == port_b_direction_q)
        else $error("Pull-up missing on input");

endmodule : pbci_port

// [shared/pbci_pkg.sv]
package pbci_pkg;

    localparam int unsigned PORT_W = 8;
    localparam int unsigned REG_AW = 4;

    // Register indices on the plain register port
    localparam logic [REG_AW-1:0] ADDR_PORT_DATA = 4'h0;
    localparam logic [REG_AW-1:0] ADDR_PORT_DIR  = 4'h1;
    localparam logic [REG_AW-1:0] ADDR_OPTION    = 4'h2;
    localparam logic [REG_AW-1:0] ADDR_INT_CTRL  = 4'h3;
    localparam logic [REG_AW-1:0] ADDR_INT_STAT  = 4'h4;
    localparam logic [REG_AW-1:0] ADDR_INT_MASK  = 4'h5;

    // Field positions
    localparam int unsigned OPT_PULLUP_N_BIT = 7;
    localparam int unsigned OPT_EDGE_SEL_BIT = 6;
    localparam int unsigned ICTL_GIE_BIT     = 7;
    localparam int unsigned ICTL_EXT_EN_BIT  = 4;
    localparam int unsigned ICTL_CHG_EN_BIT  = 3;
    localparam int unsigned ICTL_EXT_FLG_BIT = 1;
    localparam int unsigned ICTL_CHG_FLG_BIT = 0;
    localparam int unsigned STAT_CHG_BIT     = 0;
    localparam int unsigned STAT_EXT_BIT     = 1;
    localparam int unsigned CHG_LO           = 4;
    localparam int unsigned CHG_W            = 4;
    localparam int unsigned EXT_PIN          = 0;

    // Reset values
    localparam logic [PORT_W-1:0] RST_OPTION  = 8'hff;
    localparam logic [PORT_W-1:0] RST_DIR     = 8'hff;
    localparam logic [PORT_W-1:0] RST_LATCH   = 8'h00;
    localparam logic [PORT_W-1:0] RST_ICTL    = 8'h00;
    localparam logic [PORT_W-1:0] RST_STAT    = 8'h00;
    localparam logic [PORT_W-1:0] RST_MASK    = 8'h00;
    localparam logic [PORT_W-1:0] ZERO_BYTE   = 8'h00;
    localparam logic [CHG_W-1:0]  RST_REF     = 4'h0;

    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
        logic [PORT_W-1:0] pull_en;
    } pbci_pins_t;

    typedef enum logic {
        PBCI_EDGE_FALL,
        PBCI_EDGE_RISE
    } pbci_edge_t;

endpackage : pbci_pkg

// [hdl/pbci_chg_det.sv]
module pbci_chg_det
    import pbci_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire logic [CHG_W-1:0]  pin_i,
    input  wire logic [CHG_W-1:0]  is_input_i,
    input  wire logic              capture_i,
    output logic                   mismatch_o
);

    logic [CHG_W-1:0] ref_q;
    logic [CHG_W-1:0] miss;

    // Per-pin compare against last captured value
    genvar g;
    generate
        for (g = 0; g < CHG_W; g++) begin : g_cmp
            assign miss[g] = is_input_i[g] & (pin_i[g] ^ ref_q[g]);
        end
    endgenerate

    // Captured pins equal reference next cycle, ending the mismatch
    assign mismatch_o = |miss;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ref_q <= RST_REF;
        end else if (capture_i) begin
            ref_q <= pin_i;
        end
    end

    ref_follows_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        capture_i |=> ref_q == $past(pin_i)) else $error("Reference not captured");

endmodule : pbci_chg_det

// [dv/pbci_keypad.sv]
// Keypad and board model: resolves each pin from the device driver, the keys, the pull-up or a floating level
module pbci_keypad
    import pbci_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic [PORT_W-1:0] dev_out_i,
    input  wire logic [PORT_W-1:0] dev_oe_i,
    input  wire logic [PORT_W-1:0] pullup_en_i,
    input  wire logic [PORT_W-1:0] key_val_i,
    input  wire logic [PORT_W-1:0] key_en_i,
    output logic [PORT_W-1:0]      level_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // A floating pin toggles every cycle so that a stale value never looks valid
    logic [PORT_W-1:0] float_q = 8'h55;

    always_ff @(posedge ref_clk_i) float_q <= ~float_q;

    assign level_o = (dev_oe_i & dev_out_i)
                   | (~dev_oe_i & key_en_i & key_val_i)
                   | (~dev_oe_i & ~key_en_i & pullup_en_i)
                   | (~dev_oe_i & ~key_en_i & ~pullup_en_i & float_q);
endmodule : pbci_keypad

// [dv/tb_port_b_change_interrupt.sv]
module tb_port_b_change_interrupt
    import pbci_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              ref_clk_i = 1'b0;
    logic              rstn_i    = 1'b0;
    logic [REG_AW-1:0] addr      = 4'h0;
    logic [PORT_W-1:0] wdata     = 8'h00;
    logic [PORT_W-1:0] key_val   = 8'h00;
    logic [PORT_W-1:0] key_en    = 8'hff;
    logic [PORT_W-1:0] rdata, pin_lvl, pin_out, pin_oe, pu_en;
    logic              wr = 1'b0, rd = 1'b0, rd_d1 = 1'b0, cpu_int, wake, irq;
    logic [PORT_W-1:0] exp_q[$];
    logic [31:0]       seed = 32'hcf75a2b9;
    int                fails = 0, n_compared = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    pbci_port dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .pin_i(pin_lvl), .pin_o(pin_out), .pin_oe_o(pin_oe), .pullup_en_o(pu_en),
        .cpu_int_o(cpu_int), .wake_o(wake), .irq_o(irq));
    pbci_keypad keys (.ref_clk_i(ref_clk_i), .dev_out_i(pin_out), .dev_oe_i(pin_oe), .pullup_en_i(pu_en),
        .key_val_i(key_val), .key_en_i(key_en), .level_o(pin_lvl));

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs

    task automatic check(input logic [PORT_W-1:0] seen, input logic [PORT_W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Strobes stay up between back-to-back calls so no signal is assigned twice in one step
    task automatic bus(input logic w, input logic [REG_AW-1:0] a, input logic [PORT_W-1:0] d);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        if (!w) exp_q.push_back(d);
        @(posedge ref_clk_i);
    endtask : bus

    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge ref_clk_i);
    endtask : idle

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk_i) rd_d1 <= rd;
    always @(negedge ref_clk_i) begin
        if (rd_d1 && exp_q.size() == 0) check(rdata, ~rdata);
        else if (rd_d1) check(rdata, exp_q.pop_front());
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fails++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        @(posedge ref_clk_i);
        check(pu_en, 8'h00);
        check(pin_oe, 8'h00);
        bus(0, ADDR_PORT_DIR, 8'hff);
        bus(0, ADDR_OPTION, 8'hff);
        bus(0, ADDR_INT_CTRL, 8'h00);
        bus(0, 4'hf, 8'h00);
        $display("test reset values done");
        bus(1, ADDR_PORT_DATA, 8'ha5);
        bus(1, ADDR_PORT_DIR, 8'h0f);
        bus(0, ADDR_PORT_DATA, 8'ha0);
        idle(1);
        check(pin_oe, 8'hf0);
        check(pin_out, 8'ha0);
        $display("test direction done");
        bus(1, ADDR_OPTION, 8'h7f);
        key_en <= 8'hf0;
        idle(2);
        check(pu_en, 8'h0f);
        bus(0, ADDR_PORT_DATA, 8'haf);
        key_en <= 8'hff;
        $display("test pull-ups done");
        bus(1, ADDR_PORT_DIR, 8'hff);
        bus(0, ADDR_PORT_DATA, 8'h00);
        bus(1, ADDR_INT_CTRL, 8'h00);
        bus(1, ADDR_INT_STAT, 8'hff);
        bus(1, ADDR_PORT_DIR, 8'h7f);
        idle(3);
        bus(0, ADDR_INT_CTRL, 8'h00);
        bus(1, ADDR_PORT_DIR, 8'hff);
        seed = xs(seed);
        key_val <= {seed[7:4] | 4'h1, 4'h0};
        idle(3);
        bus(0, ADDR_INT_CTRL, 8'h01);
        bus(0, ADDR_INT_STAT, 8'h01);
        bus(1, ADDR_INT_CTRL, 8'h00);
        bus(0, ADDR_INT_CTRL, 8'h01);
        bus(0, ADDR_PORT_DATA, key_val);
        bus(1, ADDR_INT_CTRL, 8'h00);
        bus(0, ADDR_INT_CTRL, 8'h00);
        $display("test change detect done");
        bus(1, ADDR_INT_MASK, 8'h01);
        idle(1);
        check({7'h00, irq}, 8'h01);
        bus(1, ADDR_INT_MASK, 8'h00);
        key_val <= 8'h00;
        idle(3);
        check({7'h00, irq}, 8'h00);
        bus(1, ADDR_INT_CTRL, 8'h09);
        idle(1);
        check({6'h00, cpu_int, wake}, 8'h01);
        bus(1, ADDR_INT_CTRL, 8'h89);
        bus(0, ADDR_PORT_DATA, 8'h00);
        idle(1);
        check({6'h00, cpu_int, wake}, 8'h03);
        bus(1, ADDR_INT_CTRL, 8'h00);
        bus(1, ADDR_INT_STAT, 8'h03);
        bus(1, ADDR_INT_MASK, 8'h01);
        idle(1);
        check({5'h00, irq, cpu_int, wake}, 8'h00);
        $display("test interrupt outputs done");
        for (int s = 0; s < 2; s++) begin
            bus(1, ADDR_OPTION, {1'b1, s[0], 6'h3f});
            key_val <= {7'h00, s[0]};
            idle(3);
            bus(1, ADDR_INT_CTRL, 8'h00);
            key_val <= {7'h00, ~s[0]};
            idle(3);
            bus(0, ADDR_INT_CTRL, 8'h00);
            key_val <= {7'h00, s[0]};
            idle(3);
            bus(0, ADDR_INT_CTRL, 8'h02);
            bus(0, ADDR_INT_STAT, 8'h02);
            bus(1, ADDR_INT_STAT, 8'h03);
        end
        idle(3);
        $display("test external edge done");
        conclude();
    end
endmodule : tb_port_b_change_interrupt
